// File: rtl/nvm_sec_defines.vh
`ifndef NVM_SEC_DEFINES_VH
`define NVM_SEC_DEFINES_VH

// ----------------------------------------------------------------------
// options/security byte
// ----------------------------------------------------------------------
`define SEC_LSB 0
`define SEC_MSB 1
`define KEYEN_LSB 6
`define KEYEN_MSB 7
`define SEC_UNSECURED 2'h2
`define SEC_RECOMMENDED 2'h1
`define KEYEN_ENABLED 2'h2
`define UNSEC_BYTE 8'hFE
`define FLASH_SECURITY_REG_RESET 8'hFF

// ----------------------------------------------------------------------
// flash map and commands
// ----------------------------------------------------------------------
`define OPT_SECTOR_LO 24'hFF_FE00
`define OPT_SECTOR_HI 24'hFF_FFFF
`define OPT_BYTE_ADDR 24'hFF_FE0F
`define SECTOR_LSB 9
`define SECTOR_MASK 9'h1FF
`define FULL_LO 24'h00_0000
`define FULL_HI 24'hFF_FFFF
`define CMD_ERASE_VERIFY_ALL 4'h1
`define CMD_READ_ONCE 4'h4
`define CMD_PROGRAM 4'h6
`define CMD_ERASE_ALL 4'h8
`define CMD_ERASE_SECTOR 4'hA

// ----------------------------------------------------------------------
// debug command kinds
// ----------------------------------------------------------------------
`define DBG_KIND_CSR 2'h0
`define DBG_KIND_MASS_ERASE 2'h1
`define DBG_KIND_MEM 2'h2
`define DBG_KIND_OTHER 2'h3

// ----------------------------------------------------------------------
// reset
// ----------------------------------------------------------------------
`define RESET_VECTOR 24'hFF_FFFC
`define SYNC_WAIT 2'h3

// ----------------------------------------------------------------------
// register offsets and fields
// ----------------------------------------------------------------------
`define REG_STATUS 8'h00
`define REG_FLASH_SECURITY_REG 8'h04
`define REG_KEY0 8'h08
`define REG_KEY1 8'h0C
`define REG_KEY2 8'h10
`define REG_KEY3 8'h14
`define REG_CTRL 8'h18
`define REG_OSC 8'h1C
`define REG_WDOG 8'h20
`define REG_CAUSE 8'h24
`define ST_SECURED 0
`define ST_NORMAL 1
`define ST_DBG_ACTIVE 2
`define ST_DBG_EN 3
`define ST_KEY_OK 4
`define ST_KEY_FAIL 5
`define ST_LOADED 6
`define ST_KEY_LOCK 7
`define CTRL_KEY_GO 0
`define CTRL_DBG_EXIT 1
`define OSC_EN_BIT 0
`define WDOG_RATE_LSB 0
`define WDOG_RATE_MSB 2
`define CAUSE_CLKMON 0
`define CAUSE_WDOG 1

`endif

// File: rtl/sync_2ff.v
module sync_2ff #(
  parameter W = 1
) (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  // first stage is read by the second stage only
  reg [W-1:0] meta;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else if (clk_en_i) begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// File: rtl/backdoor_key_compare.v
module backdoor_key_compare (
  input wire [63:0] entered_i,
  input wire [63:0] stored_i,
  output reg match_o
);
  integer i;
  reg [15:0] w;

  always @* begin
    w = 16'h0000;
    match_o = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      w = stored_i[i*16 +: 16];
      // an erased or zeroed key word can never open the part
      if (w == 16'h0000 || w == 16'hFFFF) begin
        match_o = 1'b0;
      end
      if (entered_i[i*16 +: 16] != w) begin
        match_o = 1'b0;
      end
    end
  end
endmodule

// File: rtl/nvm_security_state_control.v
// Added by the designer: the address map and the address-and-strobe port.
`include "nvm_sec_defines.vh"

module nvm_security_state_control (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire clk_en_i,
  input wire mode_select_input_i,
  input wire clk_mon_fail_i,
  input wire wdog_timeout_i,
  input wire [7:0] nv_option_byte_i,
  input wire [63:0] nv_backdoor_key_i,
  input wire opt_sector_prot_i,
  input wire [7:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire flash_cmd_valid_i,
  input wire [3:0] flash_cmd_code_i,
  input wire [23:0] flash_cmd_addr_i,
  input wire flash_erase_all_done_i,
  input wire dbg_cmd_valid_i,
  input wire [1:0] dbg_cmd_kind_i,
  output reg [15:0] rdata_o,
  output reg secured_o,
  output reg normal_single_chip_o,
  output reg dbg_enable_o,
  output reg active_debug_state_o,
  output reg dbg_cmd_accept_o,
  output reg dbg_cmd_reject_o,
  output reg flash_cmd_go_o,
  output reg flash_cmd_reject_o,
  output reg [23:0] erase_lo_o,
  output reg [23:0] erase_hi_o,
  output reg prog_sec_req_o,
  output reg [7:0] prog_sec_byte_o,
  output reg reset_req_o,
  output reg [23:0] reset_vector_o
);

  // --------------------------------------------------------------------
  // state encoding
  // --------------------------------------------------------------------
  localparam [2:0] ST_WAIT = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_RUN = 3'b100;

  reg [2:0] state;
  reg [1:0] wait_cnt;
  reg [7:0] flash_security_reg;
  reg [15:0] key_entry [0:3];
  reg key_ok;
  reg key_fail;
  reg key_lock;
  reg osc_enable_bit;
  reg [2:0] watchdog_rate_field;
  reg [1:0] reset_cause;

  wire mode_sync;
  wire clk_mon_sync;
  wire key_match;
  wire [63:0] key_bus;

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  sync_2ff #(
    .W(2)
  ) u_pin_sync (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(clk_en_i),
    .async_i({clk_mon_fail_i, mode_select_input_i}),
    .sync_o({clk_mon_sync, mode_sync})
  );

  // --------------------------------------------------------------------
  // backdoor key
  // --------------------------------------------------------------------
  assign key_bus = {key_entry[3], key_entry[2], key_entry[1], key_entry[0]};

  backdoor_key_compare u_key_cmp (
    .entered_i(key_bus),
    .stored_i(nv_backdoor_key_i),
    .match_o(key_match)
  );

  // --------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------
  wire load_secured;
  wire keyen_ok;
  wire key_go;
  wire key_allowed;
  wire dbg_exit;
  wire wr_status;
  wire in_opt_sector;
  wire [23:0] opt_sector_base;
  wire touches_opt;
  wire restricted_ok;
  wire flash_ok;
  reg dbg_allowed;

  // the decode looks at the live flash byte only while loading
  assign load_secured = (nv_option_byte_i[`SEC_MSB:`SEC_LSB]
                         != `SEC_UNSECURED);

  assign keyen_ok = (flash_security_reg[`KEYEN_MSB:`KEYEN_LSB]
                     == `KEYEN_ENABLED);

  assign key_go = wr_i && (addr_i == `REG_CTRL) && wdata_i[`CTRL_KEY_GO]
                  && (state == ST_RUN);

  assign key_allowed = normal_single_chip_o && keyen_ok && !key_lock
                       && key_match;

  assign dbg_exit = wr_i && (addr_i == `REG_CTRL)
                    && wdata_i[`CTRL_DBG_EXIT];

  assign wr_status = wr_i && (addr_i == `REG_STATUS);

  assign opt_sector_base = `OPT_SECTOR_LO;

  assign in_opt_sector = (flash_cmd_addr_i[23:`SECTOR_LSB]
                          == opt_sector_base[23:`SECTOR_LSB]);

  assign touches_opt = ((flash_cmd_code_i == `CMD_ERASE_SECTOR)
                        && in_opt_sector)
                       || ((flash_cmd_code_i == `CMD_PROGRAM)
                        && (flash_cmd_addr_i == `OPT_BYTE_ADDR));

  // a secured part only gets the erase-everything path
  assign restricted_ok = !secured_o
                         || (flash_cmd_code_i == `CMD_ERASE_VERIFY_ALL)
                         || (flash_cmd_code_i == `CMD_ERASE_ALL);

  assign flash_ok = restricted_ok
                    && !(touches_opt && opt_sector_prot_i);

  always @* begin
    dbg_allowed = 1'b1;
    if (secured_o) begin
      if (normal_single_chip_o) begin
        dbg_allowed = 1'b0;
      end else begin
        case (dbg_cmd_kind_i)
          `DBG_KIND_CSR: dbg_allowed = 1'b1;
          `DBG_KIND_MASS_ERASE: dbg_allowed = 1'b1;
          `DBG_KIND_MEM: dbg_allowed = 1'b0;
          default: dbg_allowed = 1'b0;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // control state
  // --------------------------------------------------------------------
  integer k;

  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_WAIT;
      wait_cnt <= 2'h0;
      flash_security_reg <= `FLASH_SECURITY_REG_RESET;
      secured_o <= 1'b1;
      normal_single_chip_o <= 1'b1;
      dbg_enable_o <= 1'b0;
      active_debug_state_o <= 1'b0;
      dbg_cmd_accept_o <= 1'b0;
      dbg_cmd_reject_o <= 1'b0;
      flash_cmd_go_o <= 1'b0;
      flash_cmd_reject_o <= 1'b0;
      erase_lo_o <= `FULL_LO;
      erase_hi_o <= `FULL_LO;
      prog_sec_req_o <= 1'b0;
      prog_sec_byte_o <= `UNSEC_BYTE;
      key_ok <= 1'b0;
      key_fail <= 1'b0;
      key_lock <= 1'b0;
      for (k = 0; k < 4; k = k + 1) begin
        key_entry[k] <= 16'h0000;
      end
    end else if (clk_en_i) begin
      dbg_cmd_accept_o <= 1'b0;
      dbg_cmd_reject_o <= 1'b0;
      flash_cmd_go_o <= 1'b0;
      flash_cmd_reject_o <= 1'b0;
      prog_sec_req_o <= 1'b0;

      if (wr_i && (addr_i == `REG_KEY0)) begin
        key_entry[0] <= wdata_i;
      end
      if (wr_i && (addr_i == `REG_KEY1)) begin
        key_entry[1] <= wdata_i;
      end
      if (wr_i && (addr_i == `REG_KEY2)) begin
        key_entry[2] <= wdata_i;
      end
      if (wr_i && (addr_i == `REG_KEY3)) begin
        key_entry[3] <= wdata_i;
      end

      case (state)
        ST_WAIT: begin
          // let the mode pin settle through the synchroniser
          if (wait_cnt == `SYNC_WAIT) begin
            state <= ST_LOAD;
          end else begin
            wait_cnt <= wait_cnt + 2'h1;
          end
        end
        ST_LOAD: begin
          flash_security_reg <= nv_option_byte_i;
          secured_o <= load_secured;
          normal_single_chip_o <= mode_sync;
          active_debug_state_o <= !mode_sync;
          dbg_enable_o <= !(load_secured && mode_sync);
          state <= ST_RUN;
        end
        ST_RUN: begin
          // a reprogrammed code is not reloaded here, only at reset
          dbg_enable_o <= !(secured_o && normal_single_chip_o);

          if (dbg_exit) begin
            active_debug_state_o <= 1'b0;
          end

          if (dbg_cmd_valid_i) begin
            if (dbg_allowed && dbg_enable_o) begin
              dbg_cmd_accept_o <= 1'b1;
            end else begin
              dbg_cmd_reject_o <= 1'b1;
            end
          end

          if (flash_cmd_valid_i) begin
            if (flash_ok) begin
              flash_cmd_go_o <= 1'b1;
              if (flash_cmd_code_i == `CMD_ERASE_SECTOR) begin
                // whole sector, so the key and vectors go too
                erase_lo_o <= {flash_cmd_addr_i[23:`SECTOR_LSB],
                               ~`SECTOR_MASK};
                erase_hi_o <= {flash_cmd_addr_i[23:`SECTOR_LSB],
                               `SECTOR_MASK};
              end else if (flash_cmd_code_i == `CMD_ERASE_ALL) begin
                erase_lo_o <= `FULL_LO;
                erase_hi_o <= `FULL_HI;
              end else begin
                erase_lo_o <= flash_cmd_addr_i;
                erase_hi_o <= flash_cmd_addr_i;
              end
            end else begin
              flash_cmd_reject_o <= 1'b1;
            end
          end

          if (flash_erase_all_done_i) begin
            secured_o <= 1'b0;
            prog_sec_req_o <= 1'b1;
            prog_sec_byte_o <= `UNSEC_BYTE;
            flash_security_reg[`SEC_MSB:`SEC_LSB] <= `SEC_UNSECURED;
          end else if (key_go && key_allowed) begin
            secured_o <= 1'b0;
          end

          // one failed attempt locks the key path until reset,
          // which stops software from sweeping the key space
          if (key_go && !key_allowed) begin
            key_lock <= 1'b1;
          end

          // set wins over a write-one-to-clear in the same cycle
          key_ok <= (key_go && key_allowed)
                    || (key_ok && !(wr_status && wdata_i[`ST_KEY_OK]));
          key_fail <= (key_go && !key_allowed)
                      || (key_fail && !(wr_status
                                        && wdata_i[`ST_KEY_FAIL]));

          if (key_go) begin
            for (k = 0; k < 4; k = k + 1) begin
              key_entry[k] <= 16'h0000;
            end
          end
        end
        default: begin
          state <= ST_WAIT;
          wait_cnt <= 2'h0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // reset sources
  // --------------------------------------------------------------------
  // power-on, low-voltage and pin resets arrive as arst_n_i directly;
  // only the gated sources are requested from here
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      osc_enable_bit <= 1'b0;
      watchdog_rate_field <= 3'h0;
      reset_req_o <= 1'b0;
      reset_cause <= 2'h0;
      reset_vector_o <= `RESET_VECTOR;
    end else if (clk_en_i) begin
      reset_vector_o <= `RESET_VECTOR;
      if (wr_i && (addr_i == `REG_OSC)) begin
        osc_enable_bit <= wdata_i[`OSC_EN_BIT];
      end
      if (wr_i && (addr_i == `REG_WDOG)) begin
        watchdog_rate_field <= wdata_i[`WDOG_RATE_MSB:`WDOG_RATE_LSB];
      end
      reset_req_o <= (clk_mon_sync && osc_enable_bit)
                     || (wdog_timeout_i
                         && (watchdog_rate_field != 3'h0));
      if (clk_mon_sync && osc_enable_bit) begin
        reset_cause[`CAUSE_CLKMON] <= 1'b1;
      end
      if (wdog_timeout_i && (watchdog_rate_field != 3'h0)) begin
        reset_cause[`CAUSE_WDOG] <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // register read port
  // --------------------------------------------------------------------
  // key words are write only so a debugger cannot fish them back out
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      rdata_o <= 16'h0000;
      if (rd_i) begin
        case (addr_i)
          `REG_STATUS: begin
            rdata_o[`ST_SECURED] <= secured_o;
            rdata_o[`ST_NORMAL] <= normal_single_chip_o;
            rdata_o[`ST_DBG_ACTIVE] <= active_debug_state_o;
            rdata_o[`ST_DBG_EN] <= dbg_enable_o;
            rdata_o[`ST_KEY_OK] <= key_ok;
            rdata_o[`ST_KEY_FAIL] <= key_fail;
            rdata_o[`ST_LOADED] <= (state == ST_RUN);
            rdata_o[`ST_KEY_LOCK] <= key_lock;
          end
          `REG_FLASH_SECURITY_REG: rdata_o <= {8'h00, flash_security_reg};
          `REG_OSC: rdata_o <= {15'h0000, osc_enable_bit};
          `REG_WDOG: rdata_o <= {13'h0000, watchdog_rate_field};
          `REG_CAUSE: rdata_o <= {14'h0000, reset_cause};
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// File: bench/sec_checker.sv
module sec_checker (
  input wire core_clk_i,
  input wire arst_n_i,
  input wire flash_cmd_valid_i,
  input wire [3:0] flash_cmd_code_i,
  input wire [23:0] flash_cmd_addr_i,
  input wire opt_sector_prot_i,
  input wire flash_erase_all_done_i,
  input wire dbg_cmd_valid_i,
  input wire [1:0] dbg_cmd_kind_i,
  input wire secured_o,
  input wire normal_single_chip_o,
  input wire dbg_enable_o,
  input wire dbg_cmd_accept_o,
  input wire flash_cmd_go_o,
  input wire flash_cmd_reject_o,
  input wire [23:0] erase_lo_o,
  input wire [23:0] erase_hi_o,
  input wire prog_sec_req_o,
  input wire [7:0] prog_sec_byte_o,
  input wire [23:0] reset_vector_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  // ----------------------------------------------------------------
  // security state and gating
  // ----------------------------------------------------------------
  vector_fixed_a: assert property (reset_vector_o == 24'hFF_FFFC)
    else $error("reset vector moved");
  secure_hold_a: assert property (!$rose(secured_o))
    else $error("secured rose outside reset");
  debug_off_a: assert property (secured_o && normal_single_chip_o
    |-> !dbg_enable_o && !dbg_cmd_accept_o)
    else $error("debug usable while secured in normal mode");
  debug_restrict_a: assert property (dbg_cmd_valid_i && secured_o
    && !normal_single_chip_o && dbg_cmd_kind_i[1] |=> !dbg_cmd_accept_o)
    else $error("restricted debug command accepted");
  flash_restrict_a: assert property (flash_cmd_valid_i && secured_o
    && flash_cmd_code_i != 4'h1 && flash_cmd_code_i != 4'h8
    |=> !flash_cmd_go_o) else $error("restricted flash command ran");
  opt_protect_a: assert property (flash_cmd_valid_i && opt_sector_prot_i
    && flash_cmd_code_i == 4'hA && flash_cmd_addr_i[23:9] == 15'h7FFF
    |=> !flash_cmd_go_o) else $error("protected option sector erased");
  sector_range_a: assert property (flash_cmd_go_o
    && $past(flash_cmd_code_i) == 4'hA
    && $past(flash_cmd_addr_i[23:9]) == 15'h7FFF
    |-> erase_lo_o == 24'hFF_FE00 && erase_hi_o == 24'hFF_FFFF)
    else $error("option sector range wrong");
  one_answer_a: assert property (flash_cmd_go_o
    |-> !flash_cmd_reject_o && $past(flash_cmd_valid_i))
    else $error("flash answer without single request");
  erase_unsec_a: assert property (flash_erase_all_done_i
    |=> !secured_o && prog_sec_req_o && prog_sec_byte_o == 8'hFE)
    else $error("full erase did not unsecure");

  cover property (flash_cmd_go_o && erase_lo_o == 24'hFF_FE00);
  cover property ($fell(secured_o));
  cover property (dbg_cmd_accept_o && secured_o);
endmodule

// File: bench/flash_dbg_model.sv
module flash_dbg_model (
  input wire core_clk_i,
  input wire prog_sec_req_o,
  input wire [7:0] prog_sec_byte_o,
  output logic flash_cmd_valid_i,
  output logic [3:0] flash_cmd_code_i,
  output logic [23:0] flash_cmd_addr_i,
  output logic flash_erase_all_done_i,
  output logic dbg_cmd_valid_i,
  output logic [1:0] dbg_cmd_kind_i,
  output logic [7:0] nv_option_byte_i,
  output logic [63:0] nv_backdoor_key_i,
  output logic opt_sector_prot_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // secure by the inverse of the unsecured code
  initial begin
    flash_cmd_valid_i = 1'h0;
    flash_cmd_code_i = 4'h0;
    flash_cmd_addr_i = 24'h00_0000;
    flash_erase_all_done_i = 1'h0;
    dbg_cmd_valid_i = 1'h0;
    dbg_cmd_kind_i = 2'h0;
    nv_option_byte_i = 8'h01;
    nv_backdoor_key_i = 64'h1234_5678_9ABC_DEF0;
    opt_sector_prot_i = 1'h0;
  end
  // array is never reset, so the programmed byte survives resets
  always @(posedge core_clk_i) begin
    if (prog_sec_req_o) begin
      nv_option_byte_i <= prog_sec_byte_o;
    end
  end
  task load(input [7:0] ob, input [63:0] k, input p);
    nv_option_byte_i = ob;
    nv_backdoor_key_i = k;
    opt_sector_prot_i = p;
  endtask
  // released lines show the inverse so stale values are never trusted
  task fcmd(input [3:0] c, input [23:0] a);
    @(posedge core_clk_i);
    flash_cmd_valid_i <= 1'h1;
    flash_cmd_code_i <= c;
    flash_cmd_addr_i <= a;
    @(posedge core_clk_i);
    flash_cmd_valid_i <= 1'h0;
    flash_cmd_code_i <= ~c;
    flash_cmd_addr_i <= ~a;
    #1;
  endtask
  task dcmd(input [1:0] k);
    @(posedge core_clk_i);
    dbg_cmd_valid_i <= 1'h1;
    dbg_cmd_kind_i <= k;
    @(posedge core_clk_i);
    dbg_cmd_valid_i <= 1'h0;
    dbg_cmd_kind_i <= ~k;
    #1;
  endtask
  task done;
    @(posedge core_clk_i);
    flash_erase_all_done_i <= 1'h1;
    @(posedge core_clk_i);
    flash_erase_all_done_i <= 1'h0;
    #1;
  endtask
endmodule

// File: bench/nvm_security_state_control_bench.sv
module nvm_security_state_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] KEY = 64'h1234_5678_9ABC_DEF0;
  logic core_clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic clk_en_i = 1'h1;
  logic mode_select_input_i = 1'h1;
  logic clk_mon_fail_i = 1'h0;
  logic wdog_timeout_i = 1'h0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic flash_cmd_valid_i, flash_erase_all_done_i, dbg_cmd_valid_i;
  logic opt_sector_prot_i, secured_o, normal_single_chip_o, dbg_enable_o;
  logic active_debug_state_o, dbg_cmd_accept_o, dbg_cmd_reject_o;
  logic flash_cmd_go_o, flash_cmd_reject_o, prog_sec_req_o, reset_req_o;
  logic [3:0] flash_cmd_code_i;
  logic [1:0] dbg_cmd_kind_i;
  logic [7:0] nv_option_byte_i, prog_sec_byte_o;
  logic [63:0] nv_backdoor_key_i;
  logic [23:0] flash_cmd_addr_i, erase_lo_o, erase_hi_o, reset_vector_o;
  logic [15:0] rdata_o, rv;
  logic [72:0] bad [4];
  integer mismatches = 0;
  integer checked = 0;
  integer i;

  nvm_security_state_control nvm_security_state_control_inst (.*);
  flash_dbg_model flash_dbg_model_inst (.*);

  always #20 core_clk_i = ~core_clk_i;

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task end_sim;
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [23:0] got, input [23:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    @(posedge core_clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'h0;
    #1;
  endtask
  task rd(input [7:0] a);
    @(posedge core_clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'h0;
    #1 rv = rdata_o;
  endtask
  // mode pin is set well before release so the sampling sees it stable
  task rst(input m);
    @(posedge core_clk_i);
    arst_n_i <= 1'h0;
    mode_select_input_i <= m;
    repeat (8) @(posedge core_clk_i);
    arst_n_i <= 1'h1;
    repeat (8) @(posedge core_clk_i);
    #1;
  endtask
  task key(input [63:0] k);
    for (int j = 0; j < 4; j++)
      wr(8'h08 + 8'(4 * j), k[16*j +: 16]);
    wr(8'h18, 16'h0001);
  endtask

  initial begin
    #120000;
    mismatches++;
    end_sim;
  end

  initial begin
    // let the partner model's power-up values settle before loading
    #1;
    bad[0] = {1'h0, 8'h81, KEY};
    bad[1] = {1'h1, 8'h41, KEY};
    bad[2] = {1'h1, 8'h81, 64'hFFFF_5678_9ABC_DEF0};
    bad[3] = {1'h1, 8'h81, 64'h1234_5678_0000_DEF0};
    for (i = 0; i < 8; i++) begin
      flash_dbg_model_inst.load({6'h00, i[1:0]}, KEY, 1'h0);
      rst(i[2]);
      chk(secured_o, i[1:0] != 2'h2, "secured");
      chk(normal_single_chip_o, i[2], "mode");
      chk(active_debug_state_o, !i[2], "dbg active");
      chk(dbg_enable_o, !(i[2] && i[1:0] != 2'h2), "dbg en");
      chk(reset_vector_o, 24'hFF_FFFC, "vector");
      rd(8'h04);
      chk(rv, {14'h0000, i[1:0]}, "flash_security_reg copy");
    end
    // last pass left normal mode; the restricted debug set needs special
    rst(0);
    for (i = 0; i < 4; i++) begin
      flash_dbg_model_inst.dcmd(i[1:0]);
      chk(dbg_cmd_accept_o, i < 2, "ss dbg acc");
      chk(dbg_cmd_reject_o, i >= 2, "ss dbg rej");
    end
    flash_dbg_model_inst.fcmd(4'hA, 24'h00_1000);
    chk(flash_cmd_reject_o, 1, "ss flash");
    for (i = 0; i < 4; i++) begin
      flash_dbg_model_inst.load(bad[i][71:64], bad[i][63:0], 1'h0);
      rst(bad[i][72]);
      key(bad[i][63:0]);
      chk(secured_o, 1, "bad key");
    end
    flash_dbg_model_inst.load(8'h81, KEY, 1'h0);
    rst(1);
    flash_dbg_model_inst.fcmd(4'hA, 24'hFF_FE40);
    chk(flash_cmd_reject_o, 1, "ns sector");
    flash_dbg_model_inst.fcmd(4'h8, 24'h00_0040);
    chk(flash_cmd_go_o, 1, "ns erase all");
    chk(erase_hi_o, 24'hFF_FFFF, "all hi");
    flash_dbg_model_inst.dcmd(2'h0);
    chk(dbg_cmd_accept_o, 0, "ns dbg");
    key(KEY);
    chk(secured_o, 0, "key unsec");
    rd(8'h00);
    chk(rv[4], 1, "key ok");
    flash_dbg_model_inst.load(8'h02, KEY, 1'h1);
    rst(1);
    flash_dbg_model_inst.fcmd(4'hA, 24'hFF_FE40);
    chk(flash_cmd_reject_o, 1, "prot erase");
    flash_dbg_model_inst.fcmd(4'h6, 24'hFF_FE0F);
    chk(flash_cmd_reject_o, 1, "prot prog");
    flash_dbg_model_inst.load(8'h02, KEY, 1'h0);
    flash_dbg_model_inst.fcmd(4'hA, 24'hFF_FE40);
    chk(erase_lo_o, 24'hFF_FE00, "sector lo");
    chk(erase_hi_o, 24'hFF_FFFF, "sector hi");
    for (i = 0; i < 4; i++) begin
      flash_dbg_model_inst.dcmd(i[1:0]);
      chk(dbg_cmd_accept_o, 1, "open dbg");
    end
    flash_dbg_model_inst.load(8'h01, KEY, 1'h0);
    rst(1);
    flash_dbg_model_inst.load(8'h02, KEY, 1'h0);
    repeat (6) @(posedge core_clk_i);
    chk(secured_o, 1, "reprog waits");
    rst(1);
    chk(secured_o, 0, "reprog reset");
    flash_dbg_model_inst.load(8'h01, KEY, 1'h0);
    rst(1);
    flash_dbg_model_inst.done;
    chk(secured_o, 0, "erase unsec");
    chk(prog_sec_byte_o, 8'hFE, "sec byte");
    rst(1);
    chk(secured_o, 0, "erase kept");
    rd(8'h30);
    chk(rv, 0, "unmapped");
    @(posedge core_clk_i) clk_mon_fail_i <= 1'h1;
    repeat (6) @(posedge core_clk_i);
    chk(reset_req_o, 0, "clkmon gated");
    wr(8'h1C, 16'h0001);
    repeat (6) @(posedge core_clk_i);
    chk(reset_req_o, 1, "clkmon req");
    @(posedge core_clk_i) clk_mon_fail_i <= 1'h0;
    rst(1);
    @(posedge core_clk_i) wdog_timeout_i <= 1'h1;
    repeat (4) @(posedge core_clk_i);
    chk(reset_req_o, 0, "wdog gated");
    wr(8'h20, 16'h0003);
    repeat (4) @(posedge core_clk_i);
    chk(reset_req_o, 1, "wdog req");
    @(posedge core_clk_i) wdog_timeout_i <= 1'h0;
    rd(8'h24);
    chk(rv, 16'h0002, "cause wdog only");
    end_sim;
  end
endmodule

bind nvm_security_state_control sec_checker sec_checker_inst (.*);
